// ### hw/trl_pkg.sv
// Notes on behaviour
// - Power-on clear forces the first program as the active one.
// - After standby and clear both low, both high selects the first program.
// - Program lock ignores local direct, prefix, up and down program keys.
// - Remote up, down and recall still change program under lock.
// - Fine-tuning enable is driven high only when linear fine tuning runs.
// - Search sweep drives fine-tuning enable low.
// - Search digital fine-tuning interval leaves fine-tuning enable floating.
// - Program select: enable high with linear tuning on, floating when off.
// - Mute high or floating means muting on; driven low means muting off.
// - Fully automatic search drives mute high.
// - Other modes with muting on float mute; muting off drives it low.
// - Standby low inhibits functions, holds program, floats both outputs.
package trl_pkg;

    // ------------------------------------------------------------------
    // Program numbers and local key codes
    // ------------------------------------------------------------------
    localparam int           PROG_W     = 5;
    localparam logic [4:0]   FIRST_PROG = 5'h01;
    localparam logic [4:0]   PROG_MAX   = 5'h1D;
    localparam logic [4:0]   TENS_BASE  = 5'h0A;
    localparam logic [4:0]   TWEN_BASE  = 5'h14;
    localparam logic [3:0]   KEY_DIRMAX = 4'hB;
    localparam logic [3:0]   KEY_DIGMAX = 4'h9;
    localparam logic [3:0]   KEY_PRE10  = 4'hC;
    localparam logic [3:0]   KEY_PRE20  = 4'hD;
    localparam logic [3:0]   KEY_UP     = 4'hE;
    localparam logic [3:0]   KEY_DN     = 4'hF;

    // ------------------------------------------------------------------
    // Pin vector positions (all synchronised)
    // ------------------------------------------------------------------
    localparam int PIN_N    = 7;
    localparam int PIN_AC   = 0;
    localparam int PIN_STBY = 1;
    localparam int PIN_KEY  = 2;
    localparam int PIN_LOCK = 3;
    localparam int PIN_RINC = 4;
    localparam int PIN_RDEC = 5;
    localparam int PIN_RREC = 6;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL      = 8'h00;
    localparam logic [7:0] ADR_STAT      = 8'h04;
    localparam int         CTRL_LIN_BIT  = 0;
    localparam int         CTRL_MUTE_BIT = 1;
    localparam logic [1:0] CTRL_RST      = 2'h2;
    localparam int         STAT_LOCK_BIT = 8;
    localparam int         STAT_STBY_BIT = 9;

    typedef enum logic [2:0] {
        PFX_IDLE = 3'b001,
        PFX_TENS = 3'b010,
        PFX_TWEN = 3'b100
    } trl_pfx_t;

endpackage : trl_pkg

// ### hw/trl_mode_if.sv
`timescale 1ns/1ns
`default_nettype none
interface trl_mode_if;
    logic standby;
    logic sweep;
    logic dft;
    logic full_auto;
    logic lin_ft_on;
    logic mute_on;
    modport src (output standby, sweep, dft, full_auto, lin_ft_on, mute_on);
    modport enc (input  standby, sweep, dft, full_auto, lin_ft_on, mute_on);
endinterface : trl_mode_if
`default_nettype wire

// ### hw/trl_outputs.sv
`timescale 1ns/1ns
`default_nettype none
module trl_outputs
    import trl_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    trl_mode_if.enc     mode,
    output logic        ft_o,
    output logic        ft_oe_o,
    output logic        mute_o,
    output logic        mute_oe_o
);

    typedef struct packed {
        logic ft;
        logic ft_oe;
        logic mute;
        logic mute_oe;
    } trl_out_st_t;

    trl_out_st_t q, d;

    // ------------------------------------------------------------------
    // Three-state encoding
    // ------------------------------------------------------------------
    always_comb begin
        d = '0;
        if (!mode.standby) begin
            if (mode.sweep) begin
                d.ft_oe = 1'b1;
            end else if (mode.dft) begin
                d.ft_oe = 1'b0;
            end else if (mode.lin_ft_on) begin
                d.ft    = 1'b1;
                d.ft_oe = 1'b1;
            end
            if (mode.full_auto) begin
                d.mute    = 1'b1;
                d.mute_oe = 1'b1;
            end else if (!mode.mute_on) begin
                d.mute_oe = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ft_o      = q.ft;
    assign ft_oe_o   = q.ft_oe;
    assign mute_o    = q.mute;
    assign mute_oe_o = q.mute_oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_sweep_drives_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.standby && mode.sweep) |=> (ft_oe_o && !ft_o))
        else $error("sweep did not drive fine tuning low");
    a_dft_floats: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.standby && !mode.sweep && mode.dft) |=> !ft_oe_o)
        else $error("digital fine tuning did not float output");
    a_ft_high_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        (ft_oe_o && ft_o) |-> $past(mode.lin_ft_on && !mode.sweep
                                    && !mode.dft && !mode.standby))
        else $error("fine tuning high without linear tuning");
    a_select_lin: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.standby && !mode.sweep && !mode.dft)
        |=> (ft_oe_o == $past(mode.lin_ft_on)) && (ft_o == ft_oe_o))
        else $error("program select fine tuning level wrong");
    a_auto_mute_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.standby && mode.full_auto) |=> (mute_oe_o && mute_o))
        else $error("full auto search did not drive mute high");
    a_mute_off_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (!mode.standby && !mode.full_auto) |=>
        (mute_oe_o == !$past(mode.mute_on)) && !mute_o)
        else $error("mute level wrong outside full auto search");
    a_standby_float: assert property (@(posedge clk_i) disable iff (rst_i)
        mode.standby |=> (!ft_oe_o && !mute_oe_o))
        else $error("outputs driven in standby");
    c_sweep: cover property (@(posedge clk_i) disable iff (rst_i)
        mode.sweep ##1 mode.dft ##1 !mode.sweep && !mode.dft);
    c_auto: cover property (@(posedge clk_i) disable iff (rst_i)
        mode.full_auto ##1 !mode.full_auto && !mode.mute_on);

endmodule : trl_outputs
`default_nettype wire

// ### hw/trl_top.sv
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module trl_top
    import trl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Device pins
    input  wire logic        power_on_clear_n_i,
    input  wire logic        standby_n_i,
    input  wire logic        local_key_i,
    input  wire logic [3:0]  local_key_code_i,
    input  wire logic        program_lock_key_i,
    input  wire logic        program_increment_n_i,
    input  wire logic        program_decrement_n_i,
    input  wire logic        program_recall_n_i,
    // Mode sequencer, same clock
    input  wire logic        search_sweep_i,
    input  wire logic        search_dft_i,
    input  wire logic        full_auto_i,
    // Program and three-state outputs
    output logic [4:0]       program_o,
    output logic             program_lock_o,
    output logic             fine_tuning_enable_out_o,
    output logic             fine_tuning_enable_out_oe_o,
    output logic             mute_o,
    output logic             mute_oe_o
);

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        logic [3:0]       code1;
        logic [3:0]       code2;
        logic [4:0]       prog;
        logic [4:0]       last_prog;
        logic             lock;
        trl_pfx_t         pfx;
        logic             both_low;
        logic [1:0]       ctrl;
        logic             ack;
        logic [31:0]      dat;
    } trl_top_st_t;

    localparam trl_top_st_t RST_ST = '{
        s1: '0, s2: '0, s3: '0, code1: 4'h0, code2: 4'h0,
        prog: FIRST_PROG, last_prog: FIRST_PROG, lock: 1'b0,
        pfx: PFX_IDLE, both_low: 1'b0, ctrl: CTRL_RST,
        ack: 1'b0, dat: 32'h0000_0000};

    trl_top_st_t      q, d;
    logic [PIN_N-1:0] pins;
    logic             clear_lo;
    logic             stby_lo;
    logic             key_ev;
    logic             lock_ev;
    logic             rinc_ev;
    logic             rdec_ev;
    logic             rrec_ev;
    logic             req;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] prog_step(input logic [4:0] p,
                                             input logic       up);
        logic [4:0] r;
        r = p;
        if (up) begin
            r = (p >= PROG_MAX) ? 5'h00 : 5'(p + 5'h01);
        end else begin
            r = (p == 5'h00) ? PROG_MAX : 5'(p - 5'h01);
        end
        return r;
    endfunction : prog_step

    function automatic logic falls(input logic now, input logic prev);
        return prev & ~now;
    endfunction : falls

    // ------------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------------
    always_comb begin
        pins           = '0;
        pins[PIN_AC]   = power_on_clear_n_i;
        pins[PIN_STBY] = standby_n_i;
        pins[PIN_KEY]  = local_key_i;
        pins[PIN_LOCK] = program_lock_key_i;
        pins[PIN_RINC] = program_increment_n_i;
        pins[PIN_RDEC] = program_decrement_n_i;
        pins[PIN_RREC] = program_recall_n_i;
    end

    assign clear_lo = ~q.s2[PIN_AC];
    assign stby_lo  = ~q.s2[PIN_STBY];
    assign key_ev   = falls(q.s3[PIN_KEY], q.s2[PIN_KEY]);
    assign lock_ev  = falls(q.s3[PIN_LOCK], q.s2[PIN_LOCK]);
    assign rinc_ev  = falls(q.s2[PIN_RINC], q.s3[PIN_RINC]);
    assign rdec_ev  = falls(q.s2[PIN_RDEC], q.s3[PIN_RDEC]);
    assign rrec_ev  = falls(q.s2[PIN_RREC], q.s3[PIN_RREC]);
    assign req      = cyc_i & stb_i & ~q.ack;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        d.s1    = pins;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.code1 = local_key_code_i;
        d.code2 = q.code1;

        if (clear_lo && stby_lo) begin
            d.both_low = 1'b1;
        end

        if (clear_lo) begin
            d.prog      = FIRST_PROG;
            d.last_prog = FIRST_PROG;
            d.pfx       = PFX_IDLE;
            d.lock      = 1'b0;
            d.ctrl      = CTRL_RST;
        end else if (stby_lo) begin
            d.pfx = PFX_IDLE;
        end else if (q.both_low) begin
            d.both_low  = 1'b0;
            d.prog      = FIRST_PROG;
            d.last_prog = FIRST_PROG;
        end else begin
            if (lock_ev) begin
                d.lock = ~q.lock;
            end
            if (rinc_ev || rdec_ev) begin
                d.last_prog = q.prog;
                d.prog      = prog_step(q.prog, rinc_ev);
                d.pfx       = PFX_IDLE;
            end else if (rrec_ev) begin
                d.last_prog = q.prog;
                d.prog      = q.last_prog;
                d.pfx       = PFX_IDLE;
            end else if (key_ev && !q.lock) begin
                case (q.code2)
                    KEY_PRE10: begin
                        d.pfx = PFX_TENS;
                    end
                    KEY_PRE20: begin
                        d.pfx = PFX_TWEN;
                    end
                    KEY_UP, KEY_DN: begin
                        d.last_prog = q.prog;
                        d.prog      = prog_step(q.prog, q.code2 == KEY_UP);
                        d.pfx       = PFX_IDLE;
                    end
                    default: begin
                        d.last_prog = q.prog;
                        d.pfx       = PFX_IDLE;
                        d.prog      = {1'b0, q.code2};
                        if (q.code2 <= KEY_DIGMAX) begin
                            case (q.pfx)
                                PFX_TENS: d.prog = 5'(TENS_BASE + q.code2);
                                PFX_TWEN: d.prog = 5'(TWEN_BASE + q.code2);
                                default:  d.prog = {1'b0, q.code2};
                            endcase
                        end
                    end
                endcase
            end
        end

        // Register slave: answer one cycle after the request is seen
        d.ack = req;
        if (req) begin
            d.dat = 32'h0000_0000;
            case (adr_i)
                ADR_CTRL: d.dat[1:0] = q.ctrl;
                ADR_STAT: begin
                    d.dat[PROG_W-1:0]    = q.prog;
                    d.dat[STAT_LOCK_BIT] = q.lock;
                    d.dat[STAT_STBY_BIT] = stby_lo;
                end
                default: d.dat = 32'h0000_0000;
            endcase
        end
        if (cyc_i && stb_i && q.ack && we_i && sel_i[0] && !clear_lo
            && adr_i == ADR_CTRL) begin
            d.ctrl = dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= RST_ST;
        end else begin
            q <= d;
        end
    end

    assign dat_o          = q.dat;
    assign ack_o          = q.ack;
    assign program_o      = q.prog;
    assign program_lock_o = q.lock;

    // ------------------------------------------------------------------
    // Output encoder
    // ------------------------------------------------------------------
    trl_mode_if mode_if ();

    assign mode_if.standby   = stby_lo;
    assign mode_if.sweep     = search_sweep_i;
    assign mode_if.dft       = search_dft_i;
    assign mode_if.full_auto = full_auto_i;
    assign mode_if.lin_ft_on = q.ctrl[CTRL_LIN_BIT];
    assign mode_if.mute_on   = q.ctrl[CTRL_MUTE_BIT];

    trl_outputs u_outputs (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .mode      (mode_if.enc),
        .ft_o      (fine_tuning_enable_out_o),
        .ft_oe_o   (fine_tuning_enable_out_oe_o),
        .mute_o    (mute_o),
        .mute_oe_o (mute_oe_o)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_clear_first: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_lo |=> (program_o == FIRST_PROG && !program_lock_o))
        else $error("clear did not select first program");
    a_wake_first: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.both_low && !clear_lo && !stby_lo) |=> program_o == FIRST_PROG)
        else $error("wake from standby and clear skipped first program");
    a_clear_synced: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(power_on_clear_n_i) ##1 power_on_clear_n_i == 1'b0
        |-> !clear_lo ##1 clear_lo)
        else $error("clear pin not passed through two flip-flops");
    a_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.lock && key_ev && !clear_lo && !stby_lo && !q.both_low
         && !rinc_ev && !rdec_ev && !rrec_ev && !lock_ev)
        |=> $stable(program_o) && q.pfx == $past(q.pfx))
        else $error("local key changed program under lock");
    a_remote_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        (rinc_ev && !rdec_ev && !clear_lo && !stby_lo && !q.both_low)
        |=> program_o == prog_step($past(program_o), 1'b1))
        else $error("remote increment did not step program");
    a_standby_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (stby_lo && !clear_lo) |=> $stable(program_o))
        else $error("program changed in standby");
    c_lock_remote: cover property (@(posedge clk_i) disable iff (rst_i)
        q.lock && rrec_ev);
    c_prefix: cover property (@(posedge clk_i) disable iff (rst_i)
        q.pfx == PFX_TWEN ##1 q.pfx == PFX_IDLE);
    c_wake: cover property (@(posedge clk_i) disable iff (rst_i)
        q.both_low ##1 !q.both_low);

endmodule : trl_top
`default_nettype wire

// ### dv/trl_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module trl_far_model (
    input  wire logic       clk_i,
    output logic            key_o,
    output logic [3:0]      code_o,
    output logic            lock_o,
    output logic [2:0]      rem_n_o
);
    // ------------------------------------------------------------------
    // Keyboard and remote receiver pins, idle levels
    // ------------------------------------------------------------------
    initial begin
        key_o = 1'b0;
        code_o = 4'h0;
        lock_o = 1'b0;
        rem_n_o = 3'h7;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_n

    // Code settles before the press and is held two cycles after release
    task automatic local_key(input logic [3:0] c);
        code_o <= c;
        wait_n(4);
        key_o <= 1'b1;
        wait_n(6);
        key_o <= 1'b0;
        wait_n(2);
        code_o <= ~c;
        wait_n(5);
    endtask : local_key

    task automatic lock_key();
        lock_o <= 1'b1;
        wait_n(6);
        lock_o <= 1'b0;
        wait_n(6);
    endtask : lock_key

    // Which: 0 increment, 1 decrement, 2 recall; active low pulse
    task automatic remote(input int which);
        rem_n_o <= ~(3'h1 << which);
        wait_n(6);
        rem_n_o <= 3'h7;
        wait_n(6);
    endtask : remote
endmodule : trl_far_model
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import trl_pkg::*;
    typedef struct {
        string       name;
        logic [31:0] exp;
    } trl_note_t;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic        clr_n = 1'b0;
    logic        stb_n = 1'b1;
    logic        sw = 1'b0;
    logic        df = 1'b0;
    logic        fa = 1'b0;
    logic        look = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [4:0]  prog;
    logic        ft;
    logic        ft_oe;
    logic        mu;
    logic        mu_oe;
    logic        lkp;
    logic        key;
    logic [3:0]  code;
    logic        lk;
    logic [2:0]  rem_n;
    logic [31:0] seed = 32'h161e;
    logic [4:0]  cur = 5'h01;
    logic [4:0]  prv = 5'h01;
    logic [31:0] r;
    int          err_total = 0;
    int          checks = 0;
    trl_note_t   q[$];
    trl_note_t   n;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    trl_far_model trl_far_model_i (.clk_i(clk_i), .key_o(key), .code_o(code),
        .lock_o(lk), .rem_n_o(rem_n));

    trl_top trl_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .power_on_clear_n_i(clr_n), .standby_n_i(stb_n),
        .local_key_i(key), .local_key_code_i(code),
        .program_lock_key_i(lk), .program_increment_n_i(rem_n[0]),
        .program_decrement_n_i(rem_n[1]), .program_recall_n_i(rem_n[2]),
        .search_sweep_i(sw), .search_dft_i(df), .full_auto_i(fa),
        .program_o(prog), .program_lock_o(lkp), .fine_tuning_enable_out_o(ft),
        .fine_tuning_enable_out_oe_o(ft_oe), .mute_o(mu), .mute_oe_o(mu_oe));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Line code: 0 floating, 1 driven low, 2 driven high
    function automatic logic [1:0] lv(input logic oe, input logic o);
        return oe ? (o ? 2'h2 : 2'h1) : 2'h0;
    endfunction : lv

    function automatic logic [4:0] step(input logic [4:0] c, input logic up);
        if (up) return (c == 5'h1D) ? 5'h00 : c + 5'h01;
        return (c == 5'h00) ? 5'h1D : c - 5'h01;
    endfunction : step

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic setp(input logic [4:0] v);
        prv = cur;
        cur = v;
    endtask : setp

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k >= 20) err_total++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back('{"read", e});
        bus(a, 1'b0, 32'h0, 4'hF);
    endtask : rd

    task automatic stat(input logic sb, input logic l);
        rd(ADR_STAT, {22'h0, sb, l, 3'h0, cur});
    endtask : stat

    // Pin look: lock pin, program pins and both three-state lines
    task automatic probe(input logic sb, input logic l, input logic [1:0] c);
        logic [1:0] f;
        logic [1:0] m;
        f = sb ? 2'h0 : sw ? 2'h1 : df ? 2'h0 : (c[0] ? 2'h2 : 2'h0);
        m = sb ? 2'h0 : fa ? 2'h2 : (c[1] ? 2'h0 : 2'h1);
        q.push_back('{"pins", {22'h0, l, cur, f, m}});
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
    endtask : probe

    task automatic close_out();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Monitor: oldest note against each read answer or pin look
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if ((ack_o === 1'b1 && cyc && !we) || look) begin
            if (q.size() == 0) begin
                err_total++;
            end else begin
                n = q.pop_front();
                chk(n.name, look ? {22'h0, lkp, prog, lv(ft_oe, ft),
                                    lv(mu_oe, mu)} : dat_o, n.exp);
            end
        end
    end

    initial begin
        #200000;
        err_total++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        // Clear held low from time zero, a shortened supply-ramp hold
        clr_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        stat(1'b0, 1'b0);
        rd(ADR_CTRL, 32'h2);
        rd(8'h08, 32'h0);
        bus(ADR_STAT, 1'b1, 32'hFFFF, 4'hF);
        bus(ADR_CTRL, 1'b1, 32'h1, 4'h0);
        rd(ADR_CTRL, 32'h2);
        trl_far_model_i.local_key(4'h5);
        setp(5'h05);
        stat(1'b0, 1'b0);
        trl_far_model_i.local_key(KEY_PRE10);
        trl_far_model_i.local_key(4'h7);
        setp(5'h11);
        stat(1'b0, 1'b0);
        trl_far_model_i.local_key(KEY_PRE20);
        trl_far_model_i.local_key(4'h9);
        setp(5'h1D);
        stat(1'b0, 1'b0);
        trl_far_model_i.local_key(KEY_UP);
        setp(5'h00);
        stat(1'b0, 1'b0);
        trl_far_model_i.local_key(KEY_DN);
        setp(5'h1D);
        stat(1'b0, 1'b0);
        trl_far_model_i.local_key(KEY_PRE10);
        trl_far_model_i.local_key(4'hA);
        setp(5'h0A);
        stat(1'b0, 1'b0);
        repeat (4) begin
            seed = lfsr(seed);
            trl_far_model_i.local_key(4'(seed[3:0] % 4'hC));
            setp(5'(seed[3:0] % 4'hC));
            stat(1'b0, 1'b0);
        end
        // Locked: local keys refused, remote keys still act
        trl_far_model_i.lock_key();
        trl_far_model_i.local_key(4'h3);
        trl_far_model_i.local_key(KEY_UP);
        trl_far_model_i.local_key(KEY_DN);
        trl_far_model_i.local_key(KEY_PRE20);
        trl_far_model_i.local_key(4'h4);
        stat(1'b0, 1'b1);
        trl_far_model_i.remote(0);
        setp(step(cur, 1'b1));
        stat(1'b0, 1'b1);
        trl_far_model_i.remote(1);
        setp(step(cur, 1'b0));
        stat(1'b0, 1'b1);
        trl_far_model_i.remote(2);
        setp(prv);
        stat(1'b0, 1'b1);
        probe(1'b0, 1'b1, 2'h2);
        trl_far_model_i.lock_key();
        // Mode and control combinations on the two three-state pins
        repeat (16) begin
            seed = lfsr(seed);
            r = seed;
            bus(ADR_CTRL, 1'b1, {30'h0, r[4:3]}, {r[8:6], 1'b1});
            // Stray transfer to an unmapped odd address: reads 0, writes lost
            if (!r[16]) q.push_back('{"unmapped", 32'h0});
            bus({r[15:9], 1'b1}, r[16], seed, 4'hF);
            sw <= r[0];
            df <= r[1];
            fa <= r[2];
            stb_n <= ~r[5];
            repeat (3) @(posedge clk_i);
            probe(r[5], 1'b0, r[4:3]);
        end
        // Standby: functions held, both pins float, program kept
        stb_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        probe(1'b1, 1'b0, r[4:3]);
        trl_far_model_i.local_key(4'h2);
        stat(1'b1, 1'b0);
        stb_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        stat(1'b0, 1'b0);
        // Random standby and clear levels, first pass both low, then release
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            r    = seed;
            if (k == 0) r[1:0] = 2'b00;
            stb_n <= r[0];
            clr_n <= r[1];
            repeat (8) @(posedge clk_i);
            bus(ADR_CTRL, 1'b1, 32'h1, 4'hF);
            stb_n <= 1'b1;
            clr_n <= 1'b1;
            repeat (6) @(posedge clk_i);
            if (!r[1]) setp(FIRST_PROG);
            stat(1'b0, 1'b0);
            rd(ADR_CTRL, r[1] ? 32'h1 : {30'h0, CTRL_RST});
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
